/* File: logic/dmcmc_pkg.sv */
// package: register map, field layout and encodings of the dma channel mode control block
package dmcmc_pkg;

	localparam int          ADDR_WIDTH        = 8;
	localparam int          DATA_WIDTH        = 32;
	localparam logic [7:0]  CTRL_LO_OFFSET    = 8'h00;
	localparam logic [7:0]  CTRL_HI_OFFSET    = 8'h04;
	localparam logic [7:0]  CHAIN_ADDR_OFFSET = 8'h08;
	localparam logic [7:0]  SOURCE_OFFSET     = 8'h0c;
	localparam logic [7:0]  DEST_OFFSET       = 8'h10;
	localparam logic [7:0]  COUNT_OFFSET      = 8'h14;
	localparam logic [7:0]  MASTER_OFFSET     = 8'h18;
	localparam logic [7:0]  STATUS_OFFSET     = 8'h1c;

	localparam int          SINGLE_ADDR_BIT   = 0;
	localparam int          DIR_BIT           = 1;
	localparam int          SIZE_LSB          = 2;
	localparam int          SIMPLE_CHAIN_BIT  = 5;
	localparam int          XFER_ACTIVE_BIT   = 8;
	localparam int          CHAIN_EN_BIT      = 9;
	localparam int          CHAN_RESET_BIT    = 31;
	localparam int          MASTER_EN_BIT     = 0;
	localparam int          STAT_BUSY_BIT     = 0;
	localparam int          STAT_ERROR_BIT    = 1;
	localparam int          STAT_DESC_BIT     = 2;
	localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;

	localparam logic [2:0]  SIZE_1B           = 3'h0;
	localparam logic [2:0]  SIZE_2B           = 3'h1;
	localparam logic [2:0]  SIZE_4B           = 3'h2;
	localparam logic [2:0]  SIZE_8B           = 3'h3;
	localparam logic [2:0]  SIZE_4DW          = 3'h4;
	localparam logic [2:0]  SIZE_8DW          = 3'h5;
	localparam logic [2:0]  SIZE_32DW         = 3'h7;

	typedef struct packed {
		logic        single_address_select;
		logic        direction_mem_to_io;
		logic [2:0]  transfer_unit_size;
		logic        simple_chain_select;
		logic        transfer_active;
		logic        chain_enabled;
	} dmcmc_mode_type;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} dmcmc_bus_req_type;

	typedef struct packed {
		logic        valid;
		logic        mem_to_io;
		logic        single_address;
		logic [31:0] source;
		logic [31:0] destination;
		logic [8:0]  max_bytes;
	} dmcmc_op_type;

endpackage

/* File: logic/dmcmc_channel.sv */
// module: one dma channel's mode control register, chaining and transfer sequencing
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// - chain_enabled is read-only and clears when global_master_enable clears or channel_reset is written.
// - chain_enabled sets on a nonzero chain address write or descriptor load and clears on a zero write; the channel sets it only while master_enable is one.
// - at transfer end with chain_enabled set a descriptor is fetched, word 0 at the chain address and word n at loaded word 0 + 4n, and transfer goes on.
// - a nonzero write to chain_address_reg sets transfer_active and starts a transfer.
// - transfer_active clears when the transfer ends normally or on an error.
// - the channel starts operations only while transfer_active is one, using current settings; a launched one runs to op_done_in, op_error_in or channel_reset.
// - with simple_chain_select set a descriptor loads only chain, source, destination and count registers.
// - transfer_unit_size selects 1, 2, 4, 8 bytes or 4, 8, 32 doublewords per bus operation.
// - at four doublewords or larger a bus operation may move less than the configured size.
// - in single-address mode direction one moves memory to I/O and zero I/O to memory.
// - the direction bit is ignored in dual-address mode.
// - single_address_select one picks single-address transfer, zero dual-address.
module dmcmc_channel (
	input  wire logic                           clk_in,
	input  wire logic                           rst_n_in,
	input  wire logic [dmcmc_pkg::ADDR_WIDTH-1:0] avs_address_in,
	input  wire logic                           avs_read_in,
	input  wire logic                           avs_write_in,
	input  wire logic [3:0]                     avs_byteenable_in,
	input  wire logic [dmcmc_pkg::DATA_WIDTH-1:0] avs_writedata_in,
	output logic      [dmcmc_pkg::DATA_WIDTH-1:0] avs_readdata_out,
	output logic                                avs_waitrequest_out,
	output dmcmc_pkg::dmcmc_op_type             op_out,
	input  wire logic                           op_done_in,
	input  wire logic [8:0]                     op_bytes_in,
	input  wire logic                           op_error_in,
	output logic                                desc_req_out,
	output logic      [31:0]                    desc_addr_out,
	output logic      [2:0]                     desc_word_out,
	input  wire logic                           desc_valid_in,
	input  wire logic [31:0]                    desc_data_in,
	output dmcmc_pkg::dmcmc_mode_type           mode_out
);
	import dmcmc_pkg::*;

	// register map of the channel, one 32-bit word each:
	//   ctrl low word: single address, direction, unit size, simple chain, active, chain flag (read only)
	//   ctrl high word: channel reset in bit 31 (write one, reads back zero), other bits only stored
	//   chain address: a nonzero write starts the channel and, with global enable on, arms chaining
	//   source, destination, count: working registers that the datapath advances
	//   master control: global enable in bit 0
	//   status: busy, error and fetching flags, read only
	// every access takes one wait state, so read data always come from a flip-flop
	// limitation: one operation is in flight at a time; the fabric paces the channel

	typedef enum {ST_IDLE, ST_MOVE, ST_WAIT, ST_FETCH} dmcmc_phase_type;

	typedef struct packed {
		dmcmc_mode_type  mode;
		logic            master_enable;
		logic            error_seen;
		logic [31:0]     ctrl_hi;
		logic [31:0]     chain_addr;
		logic [31:0]     source;
		logic [31:0]     destination;
		logic [31:0]     count;
		logic            ack;
		logic [31:0]     rdata;
		logic [2:0]      word;
		dmcmc_phase_type phase;
		dmcmc_op_type    op;
	} dmcmc_state_type;

	dmcmc_state_type state_reg;
	dmcmc_state_type state_next;

	// bytes per bus operation for a size code; 110 falls back to one byte
	// the 8 and 32 doubleword codes suit single-address mode only; software keeps to that
	function automatic logic [8:0] unit_bytes(input logic [2:0] code);
		case (code)
			SIZE_1B:   unit_bytes = 9'h001;
			SIZE_2B:   unit_bytes = 9'h002;
			SIZE_4B:   unit_bytes = 9'h004;
			SIZE_8B:   unit_bytes = 9'h008;
			SIZE_4DW:  unit_bytes = 9'h020;
			SIZE_8DW:  unit_bytes = 9'h040;
			SIZE_32DW: unit_bytes = 9'h100;
			default:   unit_bytes = 9'h001;
		endcase
	endfunction

	// merge a write word under its byte enables
	// reads always return the full word; byte enables only shape writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] be);
		logic [31:0] result;
		result = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				result[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		merge = result;
	endfunction

	// pack the mode fields at their bit places; unused bits read as zero
	function automatic logic [31:0] mode_word(input dmcmc_mode_type m);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[SINGLE_ADDR_BIT] = m.single_address_select;
		w[DIR_BIT] = m.direction_mem_to_io;
		w[SIZE_LSB +: 3] = m.transfer_unit_size;
		w[SIMPLE_CHAIN_BIT] = m.simple_chain_select;
		w[XFER_ACTIVE_BIT] = m.transfer_active;
		w[CHAIN_EN_BIT] = m.chain_enabled;
		mode_word = w;
	endfunction

	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] wdata;
	logic [31:0] step;

	// the ack flop blocks a second hit in the cycle that answers the first
	assign wr_hit = avs_write_in && !state_reg.ack;
	assign rd_hit = avs_read_in && !state_reg.ack;

	//////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		state_next.ack = 1'b0;
		wdata = 32'h0000_0000;
		step = 32'h0000_0000;

		// one wait cycle per access gives registered read data on a fixed latency
		if (rd_hit) begin
			state_next.ack = 1'b1;
			case (avs_address_in)
				CTRL_LO_OFFSET: begin
					state_next.rdata = mode_word(state_reg.mode);
				end
				CTRL_HI_OFFSET: begin
					state_next.rdata = state_reg.ctrl_hi;
				end
				CHAIN_ADDR_OFFSET: begin
					state_next.rdata = state_reg.chain_addr;
				end
				SOURCE_OFFSET: begin
					state_next.rdata = state_reg.source;
				end
				DEST_OFFSET: begin
					state_next.rdata = state_reg.destination;
				end
				COUNT_OFFSET: begin
					state_next.rdata = state_reg.count;
				end
				MASTER_OFFSET: begin
					state_next.rdata = {31'h0000_0000, state_reg.master_enable};
				end
				STATUS_OFFSET: begin
					state_next.rdata = 32'h0000_0000;
					state_next.rdata[STAT_BUSY_BIT] = (state_reg.phase != ST_IDLE);
					state_next.rdata[STAT_ERROR_BIT] = state_reg.error_seen;
					state_next.rdata[STAT_DESC_BIT] = (state_reg.phase == ST_FETCH);
				end
				default:           state_next.rdata = UNMAPPED_READ;
			endcase
		end

		// datapath progress; software writes below override on the same cycle
		case (state_reg.phase)
			ST_IDLE: begin
				// a zero count keeps the channel parked even while active is set
				if (state_reg.mode.transfer_active && state_reg.count != 32'h0000_0000) begin
					state_next.phase = ST_MOVE;
				end
			end

			ST_MOVE: begin
				// the operation word is copied at launch, so later register writes cannot bend it
				state_next.op.valid = 1'b1;
				state_next.op.single_address = state_reg.mode.single_address_select;
				// direction only matters for single-address moves
				state_next.op.mem_to_io = state_reg.mode.single_address_select
					&& state_reg.mode.direction_mem_to_io;
				state_next.op.source = state_reg.source;
				state_next.op.destination = state_reg.destination;
				state_next.op.max_bytes = unit_bytes(state_reg.mode.transfer_unit_size);
				state_next.phase = ST_WAIT;
			end

			ST_WAIT: begin
				// an error ends the whole transfer, not only this operation
				if (op_error_in) begin
					state_next.op.valid = 1'b0;
					state_next.mode.transfer_active = 1'b0;
					state_next.error_seen = 1'b1;
					state_next.phase = ST_IDLE;
				end else if (op_done_in) begin
					// the fabric reports bytes really moved, which may fall short of the unit
					step = {23'h00_0000, op_bytes_in};
					state_next.op.valid = 1'b0;
					state_next.source = state_reg.source + step;
					state_next.destination = state_reg.destination + step;
					if (state_reg.count > step) begin
						state_next.count = state_reg.count - step;
						state_next.phase = state_reg.mode.transfer_active ? ST_MOVE : ST_IDLE;
					end else begin
						state_next.count = 32'h0000_0000;
						if (state_reg.mode.chain_enabled) begin
							state_next.word = 3'h0;
							state_next.phase = ST_FETCH;
						end else begin
							state_next.mode.transfer_active = 1'b0;
							state_next.phase = ST_IDLE;
						end
					end
				end
			end

			ST_FETCH: begin
				if (desc_valid_in) begin
					// descriptor words: chain, source, dest, count, ctrl hi, ctrl lo, spare, spare
					case (state_reg.word)
						3'h0: begin
							state_next.chain_addr = desc_data_in;
							state_next.mode.chain_enabled = 1'b1;
						end
						3'h1: begin
							state_next.source = desc_data_in;
						end
						3'h2: begin
							state_next.destination = desc_data_in;
						end
						3'h3: begin
							state_next.count = desc_data_in;
						end
						3'h4: begin
							state_next.ctrl_hi = desc_data_in;
						end
						// the active and chain bits of a ctrl word are never taken from a descriptor
						3'h5: begin
							state_next.mode.single_address_select = desc_data_in[SINGLE_ADDR_BIT];
							state_next.mode.direction_mem_to_io = desc_data_in[DIR_BIT];
							state_next.mode.transfer_unit_size = desc_data_in[SIZE_LSB +: 3];
							state_next.mode.simple_chain_select = desc_data_in[SIMPLE_CHAIN_BIT];
						end
						default: state_next.word = state_reg.word;
					endcase
					// simple chain stops after the four address and count words
					if ((state_reg.mode.simple_chain_select && state_reg.word == 3'h3)
						|| state_reg.word == 3'h7) begin
						state_next.phase = ST_IDLE;
					end else begin
						state_next.word = state_reg.word + 3'h1;
					end
				end
			end

			default: state_next.phase = ST_IDLE;
		endcase

		if (wr_hit) begin
			state_next.ack = 1'b1;
			case (avs_address_in)
				CTRL_LO_OFFSET: begin
					wdata = merge(mode_word(state_reg.mode), avs_writedata_in, avs_byteenable_in);
					state_next.mode.single_address_select = wdata[SINGLE_ADDR_BIT];
					state_next.mode.direction_mem_to_io = wdata[DIR_BIT];
					state_next.mode.transfer_unit_size = wdata[SIZE_LSB +: 3];
					state_next.mode.simple_chain_select = wdata[SIMPLE_CHAIN_BIT];
					state_next.mode.transfer_active = wdata[XFER_ACTIVE_BIT];
				end

				CTRL_HI_OFFSET: begin
					wdata = merge(state_reg.ctrl_hi, avs_writedata_in, avs_byteenable_in);
					// channel reset is a strobe: a written one acts once and reads back as zero
					if (wdata[CHAN_RESET_BIT]) begin
						state_next.mode.chain_enabled = 1'b0;
						state_next.mode.transfer_active = 1'b0;
						state_next.op.valid = 1'b0;
						state_next.phase = ST_IDLE;
					end
					state_next.ctrl_hi = wdata;
					state_next.ctrl_hi[CHAN_RESET_BIT] = 1'b0;
				end

				CHAIN_ADDR_OFFSET: begin
					wdata = merge(state_reg.chain_addr, avs_writedata_in, avs_byteenable_in);
					// a zero write only ends chaining; a transfer in flight runs to its end
					state_next.chain_addr = wdata;
					state_next.mode.chain_enabled = (wdata != 32'h0000_0000);
					if (wdata != 32'h0000_0000) begin
						state_next.mode.transfer_active = 1'b1;
						state_next.error_seen = 1'b0;
					end
				end

				SOURCE_OFFSET: begin
					state_next.source = merge(state_reg.source, avs_writedata_in, avs_byteenable_in);
				end

				DEST_OFFSET: begin
					state_next.destination = merge(state_reg.destination, avs_writedata_in, avs_byteenable_in);
				end

				// count is in bytes; the fabric may end an operation short of the unit
				COUNT_OFFSET: begin
					state_next.count = merge(state_reg.count, avs_writedata_in, avs_byteenable_in);
				end

				MASTER_OFFSET: begin
					if (avs_byteenable_in[0]) begin
						state_next.master_enable = avs_writedata_in[MASTER_EN_BIT];
					end
				end
				default: state_next.ack = 1'b1;
			endcase
		end

		// global enable clear has the last word on the chain flag, over any write or descriptor
		if (!state_next.master_enable) begin
			state_next.mode.chain_enabled = 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// the whole state clears together, so no field leaves reset half set
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// waitrequest is combinational so the wait state starts in the request's first cycle
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !state_reg.ack;
	assign avs_readdata_out    = state_reg.rdata;
	assign op_out              = state_reg.op;
	assign desc_req_out        = (state_reg.phase == ST_FETCH);
	// descriptor word n is read at chain_addr + 4n; from word 1 on, chain_addr already holds the loaded word 0
	assign desc_addr_out       = state_reg.chain_addr + {27'h000_0000, state_reg.word, 2'h0};
	assign desc_word_out       = state_reg.word;
	assign mode_out            = state_reg.mode;

endmodule

/* File: test/dmcmc_channel_assertions.sv */
// checker: port-level properties of the dma channel mode control block
`timescale 1ns/10ps
module dmcmc_checker (
	input wire logic                      clk_in,
	input wire logic                      rst_n_in,
	input wire logic [7:0]                avs_address_in,
	input wire logic                      avs_read_in,
	input wire logic                      avs_write_in,
	input wire logic [31:0]               avs_writedata_in,
	input wire logic                      avs_waitrequest_out,
	input wire dmcmc_pkg::dmcmc_op_type   op_out,
	input wire logic                      op_error_in,
	input wire logic                      desc_req_out,
	input wire logic [2:0]                desc_word_out,
	input wire dmcmc_pkg::dmcmc_mode_type mode_out
);
	import dmcmc_pkg::*;
	logic       chain_wr;
	logic [2:0] sz;
	assign chain_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == CHAIN_ADDR_OFFSET;
	assign sz = mode_out.transfer_unit_size;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	//////////////////////////////////////////////////////////////////////////////
	a_bus_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("bus answer late");
	a_chain_start: assert property (chain_wr && avs_writedata_in != 0 |-> mode_out.transfer_active)
		else $error("nonzero chain address did not start");
	a_chain_zero: assert property (chain_wr && avs_writedata_in == 0 |-> !mode_out.chain_enabled)
		else $error("zero chain address left chaining on");
	a_op_active: assert property (op_out.valid |-> mode_out.transfer_active)
		else $error("operation without transfer active");
	a_dual_dir: assert property (op_out.valid && !op_out.single_address |-> !op_out.mem_to_io)
		else $error("direction used in dual address mode");
	a_mode_follow: assert property (op_out.valid |-> op_out.single_address == mode_out.single_address_select
		&& (!op_out.single_address || op_out.mem_to_io == mode_out.direction_mem_to_io))
		else $error("operation mode differs from control");
	// size codes above 3 are doubleword multiples, so the shift skips one step
	a_size_cap: assert property (op_out.valid |-> op_out.max_bytes != 0
		&& op_out.max_bytes <= (9'h001 << ({1'b0, sz} + {3'h0, sz > 3'h3})))
		else $error("operation larger than unit size");
	a_error_stop: assert property (op_error_in && op_out.valid |=> !mode_out.transfer_active && !op_out.valid)
		else $error("error did not stop transfer");
	a_fetch_chain: assert property ($rose(desc_req_out) |-> mode_out.chain_enabled)
		else $error("descriptor fetch without chaining");
	a_simple_words: assert property (desc_req_out && mode_out.simple_chain_select |-> desc_word_out <= 3'h3)
		else $error("simple chain fetched too many words");
endmodule
bind dmcmc_channel dmcmc_checker chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
	.avs_waitrequest_out(avs_waitrequest_out), .op_out(op_out), .op_error_in(op_error_in),
	.desc_req_out(desc_req_out), .desc_word_out(desc_word_out), .mode_out(mode_out));

/* File: test/dmcmc_fabric.sv */
// partner model: system bus fabric answering data operations and descriptor reads
`timescale 1ns/10ps
module dmcmc_fabric (
	input  wire logic                    clk_in,
	input  wire logic                    rst_n_in,
	input  wire dmcmc_pkg::dmcmc_op_type op_in,
	input  wire logic                    desc_req_in,
	input  wire logic [2:0]              desc_word_in,
	input  wire logic [3:0]              delay_in,
	input  wire logic                    fail_in,
	output logic                         op_done_out,
	output logic [8:0]                   op_bytes_out,
	output logic                         op_error_out,
	output logic                         desc_valid_out,
	output logic [31:0]                  desc_data_out
);
	import dmcmc_pkg::*;
	logic [31:0] desc_mem [8];
	logic [3:0]  wait_cnt;
	logic        answered;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{op_done_out, op_bytes_out, op_error_out, desc_valid_out, desc_data_out} <= '0;
			wait_cnt <= 4'h0;
			answered <= 1'b0;
		end else begin
			op_done_out <= 1'b0;
			op_error_out <= 1'b0;
			desc_valid_out <= 1'b0;
			// stale data toggles so it is never mistaken for a fresh answer
			op_bytes_out <= ~op_bytes_out;
			desc_data_out <= ~desc_data_out;
			if (!op_in.valid)
				answered <= 1'b0;
			if ((op_in.valid && !answered) || (desc_req_in && !desc_valid_out)) begin
				wait_cnt <= wait_cnt + 4'h1;
				if (wait_cnt >= delay_in) begin
					wait_cnt <= 4'h0;
					if (op_in.valid) begin
						answered <= 1'b1;
						op_done_out <= !fail_in;
						op_error_out <= fail_in;
						op_bytes_out <= op_in.max_bytes;
					end else begin
						desc_valid_out <= 1'b1;
						desc_data_out <= desc_mem[desc_word_in];
					end
				end
			end
		end
	end
endmodule

/* File: test/dmcmc_channel_bench.sv */
// testbench: register access, transfer modes, chaining, errors and reset of one channel
`timescale 1ns/10ps
module dmcmc_channel_bench;
	import dmcmc_pkg::*;
	typedef struct packed {logic [2:0] size; logic single; logic dir; logic [8:0] max_bytes; logic m2io;} dmcmc_row_type;
	logic           clk_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0, fail = 1'b0;
	logic [7:0]     avs_address_in = 8'h00;
	logic [31:0]    avs_writedata_in = 32'h0000_0000, avs_readdata_out, desc_data, desc_addr;
	logic           avs_waitrequest_out, op_done, op_error, desc_req, desc_valid;
	logic [8:0]     op_bytes;
	logic [2:0]     desc_word;
	logic [3:0]     delay = 4'h0;
	dmcmc_op_type   op_out;
	dmcmc_mode_type mode_out;
	int             err_count = 0, comparisons = 0;
	// sizes 8 and 32 doublewords only with single address; code 110 never used
	dmcmc_row_type  rows [7] = '{'{SIZE_1B, 1'b1, 1'b1, 9'h001, 1'b1}, '{SIZE_2B, 1'b0, 1'b1, 9'h002, 1'b0},
		'{SIZE_4B, 1'b1, 1'b0, 9'h004, 1'b0}, '{SIZE_8B, 1'b0, 1'b0, 9'h008, 1'b0}, '{SIZE_4DW, 1'b1, 1'b1, 9'h020, 1'b1},
		'{SIZE_8DW, 1'b1, 1'b0, 9'h040, 1'b0}, '{SIZE_32DW, 1'b1, 1'b1, 9'h100, 1'b1}};
	always #10 clk_in = ~clk_in;
	dmcmc_channel dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_byteenable_in(4'hf),
		.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.op_out(op_out), .op_done_in(op_done), .op_bytes_in(op_bytes), .op_error_in(op_error), .desc_req_out(desc_req),
		.desc_addr_out(desc_addr), .desc_word_out(desc_word), .desc_valid_in(desc_valid), .desc_data_in(desc_data),
		.mode_out(mode_out));
	dmcmc_fabric fabric (.clk_in(clk_in), .rst_n_in(rst_n_in), .op_in(op_out), .desc_req_in(desc_req),
		.desc_word_in(desc_word), .delay_in(delay), .fail_in(fail), .op_done_out(op_done), .op_bytes_out(op_bytes),
		.op_error_out(op_error), .desc_valid_out(desc_valid), .desc_data_out(desc_data));
	//////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			err_count++;
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_in);
		avs_read_in <= rd;
		avs_write_in <= !rd;
		avs_address_in <= a;
		avs_writedata_in <= d;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 64);
		// read data are taken at the very edge that shows waitrequest low
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		if (n >= 64) begin
			err_count++;
			results();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b0, a, d, q);
	endtask
	// 0 operation issued, 1 transfer idle, 2 fetch running, 3 fetch over
	task automatic wait_for(input int which);
		logic hit;
		for (int n = 0; n < 3000; n++) begin
			@(negedge clk_in);
			case (which)
				0: hit = op_out.valid === 1'b1;
				1: hit = mode_out.transfer_active === 1'b0;
				default: hit = desc_req === (which == 2);
			endcase
			if (hit)
				return;
		end
		err_count++;
		results();
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] q;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		foreach (rows[i]) begin
			delay <= i[0] ? 4'h3 : 4'h0;
			wr(COUNT_OFFSET, 32'h0000_0100);
			wr(CTRL_LO_OFFSET, 32'h0000_0100 | {rows[i].size, rows[i].dir, rows[i].single});
			wait_for(0);
			check("max bytes", op_out.max_bytes, rows[i].max_bytes);
			check("single", op_out.single_address, rows[i].single);
			check("direction", op_out.mem_to_io, rows[i].m2io);
			wait_for(1);
			bus(1'b1, COUNT_OFFSET, 0, q);
			check("count left", q, 32'h0000_0000);
			$display("test size row %0d done", i);
		end
		wr(CTRL_LO_OFFSET, 32'h0000_0200);
		bus(1'b1, CTRL_LO_OFFSET, 0, q);
		check("chain bit write", q, 32'h0000_0000);
		for (int k = 0; k < 2; k++) begin
			wr(MASTER_OFFSET, 32'h0000_0001);
			wr(CHAIN_ADDR_OFFSET, 32'h0000_0100);
			check("chain set", mode_out.chain_enabled, 1'b1);
			check("active set", mode_out.transfer_active, 1'b1);
			wr(k ? CTRL_HI_OFFSET : MASTER_OFFSET, k ? 32'h8000_0000 : 32'h0000_0000);
			check("chain cleared", mode_out.chain_enabled, 1'b0);
			wr(CTRL_LO_OFFSET, 32'h0000_0000);
		end
		$display("test chain flag done");
		fabric.desc_mem = '{32'h0000_0200, 32'h0000_3000, 32'h0000_4000, 32'h0000_0008,
			32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
		wr(COUNT_OFFSET, 32'h0000_0004);
		wr(CTRL_LO_OFFSET, 32'h0000_0020); // direction kept clear
		wr(CHAIN_ADDR_OFFSET, 32'h0000_0100);
		wait_for(2);
		check("desc address", desc_addr, 32'h0000_0100);
		wait_for(3);
		wr(CHAIN_ADDR_OFFSET, 32'h0000_0000);
		wait_for(1);
		check("chain off", mode_out.chain_enabled, 1'b0);
		bus(1'b1, SOURCE_OFFSET, 0, q);
		check("desc source", q, 32'h0000_3008);
		bus(1'b1, CTRL_LO_OFFSET, 0, q);
		check("mode kept", q, 32'h0000_0020);
		$display("test chain transfer done");
		fail <= 1'b1;
		wr(COUNT_OFFSET, 32'h0000_0010);
		wr(CTRL_LO_OFFSET, 32'h0000_0100);
		wait_for(1);
		bus(1'b1, STATUS_OFFSET, 0, q);
		check("error flag", q[STAT_ERROR_BIT], 1'b1);
		fail <= 1'b0;
		bus(1'b1, 8'h20, 0, q);
		check("unmapped", q, UNMAPPED_READ);
		wr(CTRL_LO_OFFSET, 32'h0000_003f);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		bus(1'b1, CTRL_LO_OFFSET, 0, q);
		check("reset value", q, CTRL_RESET);
		$display("test error and reset done");
		results();
	end
endmodule
